// File: common/osc_ctrl_pkg.sv
// Purpose: Shared constants and types for the oscillator control register block
// Assumes: 32-bit APB register bus, single clock domain
// Notes: Register word layout, reset values, offsets and source codes live here
package osc_ctrl_pkg;

	// Register map (byte addresses)
	localparam logic [11:0] OSC_CTRL_OFFSET = 12'h000;
	localparam logic [11:0] UNLOCK_OFFSET = 12'h004;

	// Unlock key pair, written in order to the unlock register
	localparam logic [31:0] UNLOCK_KEY_ONE = 32'hAA99_6655;
	localparam logic [31:0] UNLOCK_KEY_TWO = 32'h5566_99AA;

	// Field positions inside the oscillator control word
	localparam int PLL_ODIV_LSB = 27;
	localparam int FRC_DIV_LSB = 24;
	localparam int SOSC_RDY_BIT = 22;
	localparam int PB_RDY_BIT = 21;
	localparam int PB_DIV_LSB = 19;
	localparam int PLL_MULT_LSB = 16;
	localparam int CUR_SRC_LSB = 12;
	localparam int NEW_SRC_LSB = 8;
	localparam int SEL_LOCK_BIT = 7;
	localparam int USB_LOCK_BIT = 6;
	localparam int SYS_LOCK_BIT = 5;
	localparam int SLEEP_BIT = 4;
	localparam int FAIL_BIT = 3;
	localparam int USB_FRC_BIT = 2;
	localparam int SOSC_EN_BIT = 1;
	localparam int SWITCH_BIT = 0;

	// Fixed reset values
	localparam logic [2:0] FRC_DIV_RESET = 3'h1;
	localparam logic [1:0] PB_DIV_RESET = 2'h3;

	// Clock switch settle time, in cycles
	localparam logic [3:0] SWITCH_CYCLES = 4'h8;

	// Clock source codes
	localparam logic [2:0] SRC_FRC = 3'h0;
	localparam logic [2:0] SRC_FRC_PLL = 3'h1;
	localparam logic [2:0] SRC_PRI = 3'h2;
	localparam logic [2:0] SRC_PRI_PLL = 3'h3;
	localparam logic [2:0] SRC_SEC = 3'h4;
	localparam logic [2:0] SRC_LOW_POWER_RC_OSCILLATOR = 3'h5;
	localparam logic [2:0] SRC_FRC_DIV16 = 3'h6;
	localparam logic [2:0] SRC_FRC_DIVN = 3'h7;

	// Configuration fuse values seen at reset
	typedef struct packed {
		logic [2:0] fuseSourceSelect;
		logic [1:0] switchMonitorConfig;
		logic [2:0] fusePllOdiv;
		logic [1:0] fusePbDiv;
		logic [2:0] fusePllMult;
		logic fuseSoscEnable;
	} fuse_type;

	// Status coming in from oscillators, PLLs and the monitor
	typedef struct packed {
		logic secondaryOscStable;
		logic periphDivisorWritable;
		logic usbPllLocked;
		logic systemPllLocked;
		logic clockFailEvent;
	} osc_status_type;

	// Settings driven out to the clock tree
	typedef struct packed {
		logic [8:0] pllOutDivide;
		logic [8:0] fastRcDivide;
		logic [3:0] periphDivide;
		logic [4:0] pllMultiply;
		logic [2:0] currentSource;
		logic sleepOnWait;
		logic usbFastRcSelect;
		logic secondaryOscEnable;
	} clk_setting_type;

endpackage

// File: design/div_code_decode.sv
// Purpose: Turns a 3-bit power-of-two divider code into its divide factor
// Assumes: Codes 0 to 6 give 2**code, code 7 gives 256
// Notes: Shared by the PLL output divider and the fast RC divider
`timescale 1ns/1ps
`default_nettype none
module div_code_decode
	import osc_ctrl_pkg::*;
(
	input wire logic [2:0] code,
	output logic [8:0] factor
);

	// Top code skips 128 and jumps straight to 256
	assign factor = (code == 3'h7) ? 9'h100 : (9'h001 << code);

endmodule
`default_nettype wire

// File: design/unlock_sequencer.sv
// Purpose: Tracks the two-word unlock sequence that arms register writes
// Assumes: Keys arrive as APB writes to the unlock register
// Notes: Armed state lasts until one write to the control register consumes it or any further write to the unlock register drops it
`timescale 1ns/1ps
`default_nettype none
module unlock_sequencer
	import osc_ctrl_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic keyWrite,
	input wire logic [31:0] keyData,
	input wire logic consume,
	output logic unlocked
);

	typedef enum logic [1:0] {LOCKED, HALF, OPEN} unlock_state_type;
	unlock_state_type state_reg;
	unlock_state_type state_next;

	// Any wrong key drops back to locked, so a stray write cannot half-arm it
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			LOCKED: begin
				if (keyWrite && keyData == UNLOCK_KEY_ONE) begin
					state_next = HALF;
				end
			end
			HALF: begin
				if (keyWrite) begin
					state_next = (keyData == UNLOCK_KEY_TWO) ? OPEN : LOCKED;
				end
			end
			OPEN: begin
				if (consume || keyWrite) begin
					state_next = LOCKED;
				end
			end
			default: state_next = LOCKED;
		endcase
	end

	// State register
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_reg <= LOCKED;
		end else begin
			state_reg <= state_next;
		end
	end

	assign unlocked = (state_reg == OPEN);

endmodule
`default_nettype wire

// File: design/oscillator_control_register.sv
// Purpose: Oscillator control register with APB access and clock switch sequencing
// Assumes: Status inputs and fuse values are synchronous to mclk
// Notes: Writes need the unlock sequence; one write per unlock
// Summary of operation
// - PLL output divider bits 29:27 divide by 1,2,4,8,16,32,64,256.
// - Fast RC divider bits 26:24 same factors, reset code 001.
// - Bit 22 reads 1 only while secondary oscillator runs stable.
// - Bit 21 shows divisor writability; divisor writes honoured only then.
// - Bits 20:19 divide system clock by 1,2,4,8; reset code 11 (the code reloads them from the fuse value one cycle after reset releases).
// - PLL multiplier bits 18:16 give 15 through 21 and 24.
// - Read-only bits 14:12 show the active clock source code.
// - Writable bits 10:8 hold the requested source, same encoding.
// - Reset loads the new source field from the fuse select value.
// - With monitor config 1x, bit 7 locks clock and PLL selections.
// - With monitor config 0x, selections never lock.
// - Bit 6 reads 1 when USB PLL locked or start timer done.
// - Bit 5 reads 1 when system PLL locked or start timer done.
// - Bit 4 picks Sleep when 1, Idle when 0, on wait.
// - Bit 3 sets on a detected clock failure.
// - Writes without the unlock sequence are ignored.
// - Bits 31:30, 23, 15 and 11 always read zero.
// - Writing bit 0 starts a switch; hardware clears it when done.
// - Bit 1 enables the secondary oscillator.
// - Bit 2 selects fast RC as USB clock source when 1.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module oscillator_control_register
	import osc_ctrl_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire fuse_type fuses,
	input wire osc_status_type oscStatus,
	output var clk_setting_type clkSetting,
	output logic switchBusy
);

	// Register fields
	logic [2:0] pll_output_divider_reg;
	logic [2:0] fast_rc_divider_reg;
	logic [1:0] periph_bus_divisor_reg;
	logic [2:0] pll_multiplier_reg;
	logic [2:0] curSrc_reg;
	logic [2:0] newSrc_reg;
	logic selLock_reg;
	logic sleepOnWait_reg;
	logic failFlag_reg;
	logic usbFrc_reg;
	logic secondary_osc_enable_reg;
	logic switchReq_reg;
	logic [3:0] switchCnt_reg;
	logic [3:0] switchCnt_next;
	logic fuseLoad_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	clk_setting_type clkSetting_reg;
	logic [8:0] pllOutFactor;
	logic [8:0] frcFactor;

	// Bus decode
	wire setupPhase = psel && !penable;
	wire accessDone = psel && penable && pready_reg;
	wire hitCtrl = (paddr == OSC_CTRL_OFFSET);
	wire hitKey = (paddr == UNLOCK_OFFSET);
	wire unmapped = !hitCtrl && !hitKey;
	wire unlocked;
	wire ctrlWrite = accessDone && pwrite && hitCtrl && unlocked;
	wire keyWrite = accessDone && pwrite && hitKey;
	wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	wire [31:0] wval = pwdata & wmask;
	wire [31:0] wen = wmask;

	// Lock only when monitor config upper bit is set
	wire selLocked = fuses.switchMonitorConfig[1] && selLock_reg;
	wire selWrite = ctrlWrite && !selLocked;
	wire pbWrite = ctrlWrite && oscStatus.periphDivisorWritable;
	wire switchDone = switchReq_reg && (switchCnt_reg == SWITCH_CYCLES);

	// Readback word; unimplemented bits are constant zero
	wire [31:0] readWord = {2'h0, pll_output_divider_reg, fast_rc_divider_reg, 1'h0,
		oscStatus.secondaryOscStable, oscStatus.periphDivisorWritable,
		periph_bus_divisor_reg, pll_multiplier_reg, 1'h0, curSrc_reg, 1'h0, newSrc_reg,
		selLock_reg, oscStatus.usbPllLocked, oscStatus.systemPllLocked,
		sleepOnWait_reg, failFlag_reg, usbFrc_reg, secondary_osc_enable_reg, switchReq_reg};

	unlock_sequencer unlockSeq (
		.mclk(mclk),
		.resetn(resetn),
		.keyWrite(keyWrite),
		.keyData(pwdata),
		.consume(accessDone && pwrite && hitCtrl),
		.unlocked(unlocked)
	);

	div_code_decode pllOutDec (
		.code(pll_output_divider_reg),
		.factor(pllOutFactor)
	);

	div_code_decode frcDec (
		.code(fast_rc_divider_reg),
		.factor(frcFactor)
	);

	// APB answer: no wait states, ready in the first access cycle, error on unmapped
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			pready_reg <= setupPhase;
			pslverr_reg <= setupPhase && unmapped;
			prdata_reg <= (setupPhase && hitCtrl && !pwrite) ? readWord : 32'h0000_0000;
		end
	end

	// Fuse-backed fields reload one cycle after reset releases
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			fuseLoad_reg <= 1'b1;
		end else begin
			fuseLoad_reg <= 1'b0;
		end
	end

	// Selection fields: locked against writes when the lock applies
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pll_output_divider_reg <= 3'h0;
			pll_multiplier_reg <= 3'h0;
			newSrc_reg <= 3'h0;
			fast_rc_divider_reg <= FRC_DIV_RESET;
		end else if (fuseLoad_reg) begin
			pll_output_divider_reg <= fuses.fusePllOdiv;
			pll_multiplier_reg <= fuses.fusePllMult;
			newSrc_reg <= fuses.fuseSourceSelect;
		end else if (selWrite) begin
			if (wen[PLL_ODIV_LSB+2]) pll_output_divider_reg <= wval[PLL_ODIV_LSB+:3];
			if (wen[FRC_DIV_LSB]) fast_rc_divider_reg <= wval[FRC_DIV_LSB+:3];
			if (wen[PLL_MULT_LSB]) pll_multiplier_reg <= wval[PLL_MULT_LSB+:3];
			if (wen[NEW_SRC_LSB]) newSrc_reg <= wval[NEW_SRC_LSB+:3];
		end
	end

	// Peripheral divisor, gated by the writable status
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			periph_bus_divisor_reg <= PB_DIV_RESET;
		end else if (fuseLoad_reg) begin
			periph_bus_divisor_reg <= fuses.fusePbDiv;
		end else if (pbWrite && wen[PB_DIV_LSB]) begin
			periph_bus_divisor_reg <= wval[PB_DIV_LSB+:2];
		end
	end

	// Low byte control bits
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			selLock_reg <= 1'b0;
			sleepOnWait_reg <= 1'b0;
			usbFrc_reg <= 1'b0;
			secondary_osc_enable_reg <= 1'b0;
		end else if (fuseLoad_reg) begin
			secondary_osc_enable_reg <= fuses.fuseSoscEnable;
		end else if (ctrlWrite && wen[0]) begin
			selLock_reg <= wval[SEL_LOCK_BIT] | selLocked;
			sleepOnWait_reg <= wval[SLEEP_BIT];
			usbFrc_reg <= wval[USB_FRC_BIT];
			secondary_osc_enable_reg <= wval[SOSC_EN_BIT];
		end
	end

	// Fail flag: a failure event beats a software clear in the same cycle
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			failFlag_reg <= 1'b0;
		end else if (oscStatus.clockFailEvent) begin
			failFlag_reg <= 1'b1;
		end else if (ctrlWrite && wen[0]) begin
			failFlag_reg <= wval[FAIL_BIT];
		end
	end

	// Switch counter runs while a request is pending
	assign switchCnt_next = switchReq_reg ? switchCnt_reg + 4'h1 : 4'h0;

	// Switch sequencer; current source is fuse value after reset
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			switchReq_reg <= 1'b0;
			switchCnt_reg <= 4'h0;
			curSrc_reg <= SRC_FRC;
		end else if (fuseLoad_reg) begin
			curSrc_reg <= fuses.fuseSourceSelect;
		end else if (switchDone) begin
			curSrc_reg <= newSrc_reg;
			switchReq_reg <= 1'b0;
			switchCnt_reg <= 4'h0;
		end else begin
			if (selWrite && wen[0] && wval[SWITCH_BIT]) begin
				switchReq_reg <= 1'b1;
			end
			switchCnt_reg <= switchCnt_next;
		end
	end

	// Settings out to the clock tree, registered
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			clkSetting_reg <= '0;
		end else begin
			clkSetting_reg.pllOutDivide <= pllOutFactor;
			clkSetting_reg.fastRcDivide <= frcFactor;
			clkSetting_reg.periphDivide <= 4'h1 << periph_bus_divisor_reg;
			clkSetting_reg.pllMultiply <= (pll_multiplier_reg == 3'h7) ? 5'h18 :
				5'h0F + {2'h0, pll_multiplier_reg};
			clkSetting_reg.currentSource <= curSrc_reg;
			clkSetting_reg.sleepOnWait <= sleepOnWait_reg;
			clkSetting_reg.usbFastRcSelect <= usbFrc_reg;
			clkSetting_reg.secondaryOscEnable <= secondary_osc_enable_reg;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign clkSetting = clkSetting_reg;
	assign switchBusy = switchReq_reg;

	// Writes without unlock leave the new source unchanged
	a_locked_write: assert property (@(posedge mclk) disable iff (!resetn)
		(accessDone && pwrite && hitCtrl && !unlocked && !fuseLoad_reg) |=> $stable(newSrc_reg))
		else $error("locked write changed new source");

	// A switch completes in fixed cycles and copies the source
	a_switch_done: assert property (@(posedge mclk) disable iff (!resetn)
		switchDone |=> (curSrc_reg == $past(newSrc_reg) && !switchReq_reg))
		else $error("switch completion wrong");

	// Pending switch clears within bound
	a_switch_bound: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(switchReq_reg) |-> ##[1:10] !switchReq_reg)
		else $error("switch did not complete");

	// Fail event always shows as set next cycle
	a_fail_sticky: assert property (@(posedge mclk) disable iff (!resetn)
		oscStatus.clockFailEvent |=> failFlag_reg)
		else $error("clock fail not flagged");

	// Locked selections resist writes
	a_sel_locked: assert property (@(posedge mclk) disable iff (!resetn)
		(selLocked && !fuseLoad_reg) |=> $stable(pll_multiplier_reg))
		else $error("locked multiplier changed");

	// Divisor stable while not writable
	a_pb_guard: assert property (@(posedge mclk) disable iff (!resetn)
		(!oscStatus.periphDivisorWritable && !fuseLoad_reg) |=> $stable(periph_bus_divisor_reg))
		else $error("divisor changed while not writable");

	// Reserved readback bits zero
	a_reserved_zero: assert property (@(posedge mclk) disable iff (!resetn)
		(prdata_reg[31:30] == 2'h0 && !prdata_reg[23] && !prdata_reg[15] && !prdata_reg[11]))
		else $error("reserved bits nonzero");

	// Fuse source loaded right after reset
	// The load edge is the first one that sees reset released, not the releasing edge
	a_fuse_load: assert property (@(posedge mclk) disable iff (!resetn)
		(resetn && fuseLoad_reg) |=> (newSrc_reg == $past(fuses.fuseSourceSelect)))
		else $error("fuse source not loaded");

	// A permitted write of bit 0 arms a switch on the next edge unless a switch completes in that cycle
	a_switch_start: assert property (@(posedge mclk) disable iff (!resetn)
		(selWrite && wen[SWITCH_BIT] && wval[SWITCH_BIT] && !switchDone && !fuseLoad_reg)
		|=> switchReq_reg)
		else $error("switch request not started");

	// Once locking applies the lock bit cannot be cleared by software
	a_lock_sticky: assert property (@(posedge mclk) disable iff (!resetn)
		(resetn && selLocked) |=> selLock_reg)
		else $error("selection lock cleared while locked");

	// Locked selections also keep the requested source
	a_src_locked: assert property (@(posedge mclk) disable iff (!resetn)
		(selLocked && !fuseLoad_reg) |=> $stable(newSrc_reg))
		else $error("locked new source changed");

endmodule
`default_nettype wire

// File: tb/tb_oscillator_control_register.sv
// Purpose: Self-checking bench for the oscillator control register
// Assumes: APB slave answers after one access cycle; fuses are random per reset
// Notes: Integer model of every field is compared on each read and on clkSetting
`timescale 1ns/1ps
`default_nettype none
module tb_oscillator_control_register
	import osc_ctrl_pkg::*;
;
	logic mclk, resetn, psel, penable, pwrite, pready, pslverr, switchBusy;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic [3:0] pstrb;
	fuse_type fuses;
	osc_status_type oscStatus;
	clk_setting_type clkSetting;
	logic [2:0] mOdiv, mFrc, mMult, mCur, mNew;
	logic [1:0] mPb;
	logic mLock, mSlp, mCf, mUfrc, mSosc, mSw;
	int nErrors = 0;
	int checksDone = 0;
	int n;

	oscillator_control_register i_oscillator_control_register (.mclk(mclk), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fuses(fuses),
		.oscStatus(oscStatus), .clkSetting(clkSetting), .switchBusy(switchBusy));

	// Free-running 200 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic giveVerdict();
		$display("Checks %0d errors %0d", checksDone, nErrors);
		if (nErrors == 0 && checksDone > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			nErrors++;
			$display("ERROR %0t word got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkSet(input clk_setting_type got, input clk_setting_type exp);
		checksDone++;
		if (got !== exp) begin
			nErrors++;
			$display("ERROR %0t settings got %h expected %h", $time, got, exp);
		end
	endtask

	// Read image built from the model plus the live status inputs
	function automatic logic [31:0] expWord();
		return {2'h0, mOdiv, mFrc, 1'b0, oscStatus.secondaryOscStable,
			oscStatus.periphDivisorWritable, mPb, mMult, 1'b0, mCur, 1'b0, mNew, mLock,
			oscStatus.usbPllLocked, oscStatus.systemPllLocked, mSlp, mCf, mUfrc, mSosc, mSw};
	endfunction

	function automatic clk_setting_type expSet();
		clk_setting_type s;
		s.pllOutDivide = (mOdiv == 3'h7) ? 9'h100 : 9'(1 << mOdiv);
		s.fastRcDivide = (mFrc == 3'h7) ? 9'h100 : 9'(1 << mFrc);
		s.periphDivide = 4'(1 << mPb);
		s.pllMultiply = (mMult == 3'h7) ? 5'h18 : 5'h0F + 5'(mMult);
		s.currentSource = mCur;
		s.sleepOnWait = mSlp;
		s.usbFastRcSelect = mUfrc;
		s.secondaryOscEnable = mSosc;
		return s;
	endfunction

	// Held request until pready is sampled high, then released
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int k;
		k = 0;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			nErrors++;
			$display("ERROR %0t no bus answer", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Control write, optionally after the key pair; model follows the same rules
	task automatic wctl(input logic [31:0] wd, input logic unl);
		logic [31:0] rd;
		logic err, lk;
		if (unl) begin
			apb(1'b1, UNLOCK_OFFSET, UNLOCK_KEY_ONE, rd, err);
			apb(1'b1, UNLOCK_OFFSET, UNLOCK_KEY_TWO, rd, err);
		end
		apb(1'b1, OSC_CTRL_OFFSET, wd, rd, err);
		if (unl) begin
			lk = fuses.switchMonitorConfig[1] & mLock;
			// Each field only moves when its byte strobe is on
			if (!lk && pstrb[3]) begin
				{mOdiv, mFrc} = wd[29:24];
			end
			if (!lk && pstrb[2]) begin
				mMult = wd[18:16];
			end
			if (!lk && pstrb[1]) begin
				mNew = wd[10:8];
			end
			if (!lk && pstrb[0] && wd[0]) begin
				mSw = 1'b1;
			end
			if (pstrb[2] && oscStatus.periphDivisorWritable) begin
				mPb = wd[20:19];
			end
			if (pstrb[0]) begin
				mLock = lk | wd[7];
				mSlp = wd[4];
				mCf = wd[3];
				mUfrc = wd[2];
				mSosc = wd[1];
			end
		end
	endtask

	task automatic rdChk();
		logic [31:0] rd;
		logic err;
		apb(1'b0, OSC_CTRL_OFFSET, 32'h0, rd, err);
		chkWord({31'h0, err}, 32'h0);
		chkWord(rd, expWord());
		chkSet(clkSetting, expSet());
	endtask

	// Fresh random fuses each reset, monitor config forced
	task automatic doReset(input logic [1:0] cfg);
		fuse_type f;
		f = fuse_type'(14'($urandom));
		f.switchMonitorConfig = cfg;
		@(posedge mclk);
		resetn <= 1'b0;
		fuses <= f;
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		{mOdiv, mPb, mMult, mNew, mCur, mSosc} = {f.fusePllOdiv, f.fusePbDiv, f.fusePllMult,
			f.fuseSourceSelect, f.fuseSourceSelect, f.fuseSoscEnable};
		mFrc = FRC_DIV_RESET;
		{mLock, mSlp, mCf, mUfrc, mSw} = 5'h00;
		repeat (2) @(posedge mclk);
	endtask

	task automatic setStatus();
		oscStatus <= osc_status_type'({4'($urandom), 1'b0});
		@(posedge mclk);
	endtask

	// Hang guard, far beyond the expected run
	initial begin
		#200000;
		nErrors++;
		$display("ERROR %0t watchdog expired", $time);
		giveVerdict();
	end

	initial begin
		logic [31:0] rd;
		logic err;
		{resetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hF;
		fuses = '0;
		oscStatus = '0;
		void'($urandom(59));
		doReset(2'b00);
		setStatus();
		rdChk();
		wctl(32'h3FFF_FFF6, 1'b0);
		rdChk();
		// Every code of the PLL output and fast RC dividers, multiplier and source field
		for (int i = 0; i < 8; i++) begin
			setStatus();
			d = $urandom & 32'hFFFF_FFF6;
			d[29:27] = i[2:0];
			d[26:24] = 3'h7 - i[2:0];
			d[18:16] = i[2:0];
			d[10:8] = i[2:0];
			wctl(d, 1'b1);
			rdChk();
		end
		oscStatus.clockFailEvent <= 1'b1;
		@(posedge mclk);
		oscStatus.clockFailEvent <= 1'b0;
		mCf = 1'b1;
		rdChk();
		wctl(expWord() & 32'hFFFF_FFF6, 1'b1);
		rdChk();
		// Switch to each source and wait for hardware completion
		for (int i = 0; i < 8; i++) begin
			wctl((expWord() & 32'hFFFF_F8F6) | (32'(i) << 8) | 32'h1, 1'b1);
			@(posedge mclk);
			#1;
			chkWord({31'h0, switchBusy}, 32'h1);
			n = 0;
			while (switchBusy !== 1'b0 && n < 40) begin
				@(posedge mclk);
				n++;
			end
			chkWord(32'(n), 32'(SWITCH_CYCLES) + 32'h1);
			mCur = mNew;
			mSw = 1'b0;
			rdChk();
		end
		// Only the source byte is enabled, so the switch bit in the data is masked off
		pstrb <= 4'h2;
		wctl($urandom | 32'h1, 1'b1);
		rdChk();
		pstrb <= 4'hF;
		apb(1'b0, 12'h008, 32'h0, rd, err);
		chkWord({31'h0, err}, 32'h1);
		chkWord(rd, 32'h0);
		// Locking with monitor config 1x, then none with 0x
		doReset(2'b10);
		rdChk();
		wctl((expWord() & 32'hFFFF_FFF6) | 32'h80, 1'b1);
		rdChk();
		wctl($urandom & 32'hFFFF_FF77, 1'b1);
		rdChk();
		doReset(2'b01);
		wctl(($urandom & 32'hFFFF_FFF6) | 32'h80, 1'b1);
		wctl($urandom & 32'hFFFF_FF76, 1'b1);
		rdChk();
		giveVerdict();
	end
endmodule
`default_nettype wire
